// *** gcd_top.sv ***
// Clock output dividers, lock flag routing and interrupts on AXI4-Lite.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "gcd_params.svh"
module gcd_top #(
	parameter int NPINS = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire gcd_pkg::gcd_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output gcd_pkg::gcd_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire gcd_pkg::gcd_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output gcd_pkg::gcd_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] vco_tick,
	input wire logic [2:0] freq_lock,
	input wire logic [3:0] sys_src_tick,
	input wire logic [3:0] sys_src_tick_44k,
	input wire logic [4:0] sys_rate_field,
	input wire logic [3:0] async_src_tick,
	input wire logic [3:0] async_src_tick_44k,
	input wire logic [4:0] async_rate_field,
	output logic [NPINS-1:0] gpio_out,
	output logic [NPINS-1:0] gpio_oe,
	output logic irq
);
	import gcd_pkg::*;
	localparam int NL = 3;
	localparam logic [9:0] LOOP_IDX [NL] = '{`GCD_LOOP1_IDX,
		`GCD_LOOP2_IDX, `GCD_LOOP3_IDX};

	gcd_reg_t loop_ctrl_r [NL];
	gcd_reg_t sys_ctrl_r;
	gcd_reg_t async_ctrl_r;
	gcd_fn_t pin_fn_r [NPINS];
	logic [NL-1:0] status_r;
	logic [NL-1:0] mask_r;
	logic [NL-1:0] evt;
	logic [NL-1:0] clr;
	logic [NL-1:0] loop_clk;
	logic sys_clk;
	logic async_clk;
	logic aw_full_r;
	logic w_full_r;
	logic bvalid_r;
	logic rvalid_r;
	logic [9:0] aw_idx_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_word;
	gcd_resp_t bresp_r;
	gcd_resp_t rresp_r;
	logic [NPINS-1:0] route_oe;
	logic [NPINS-1:0] route_val;
	logic [NPINS-1:0] gpio_out_r;
	logic [NPINS-1:0] gpio_oe_r;

	function automatic gcd_reg_t merge(gcd_reg_t old, logic [31:0] d,
		logic [3:0] s, gcd_reg_t m);
		gcd_reg_t n;
		n = old;
		if (s[0]) begin
			n[7:0] = d[7:0];
		end
		if (s[1]) begin
			n[15:8] = d[15:8];
		end
		return n & m;
	endfunction

	function automatic logic mapped(logic [9:0] idx);
		logic hit;
		hit = (idx == `GCD_SYS_IDX) || (idx == `GCD_ASYNC_IDX) ||
			(idx == `GCD_LOOP1_IDX) || (idx == `GCD_LOOP2_IDX) ||
			(idx == `GCD_LOOP3_IDX) || (idx == `GCD_STAT_IDX) ||
			(idx == `GCD_MASK_IDX) || (idx == `GCD_LEVEL_IDX);
		return hit || (idx >= `GCD_PIN_IDX &&
			idx < 10'(`GCD_PIN_IDX + NPINS));
	endfunction

	// Reserved select codes give no tick, so the output simply stalls.
	function automatic logic pick_tick(logic [2:0] sel, logic [4:0] rate,
		logic [3:0] base, logic [3:0] k44);
		logic [3:0] src;
		src = (rate[4:3] == `GCD_RATE_44K) ? k44 : base;
		return sel[2] ? 1'b0 : src[sel[1:0]];
	endfunction

	function automatic logic [1:0] pin_route(gcd_fn_t fn, logic [2:0] lc,
		logic [2:0] lk, logic sc, logic ac);
		logic [1:0] r;
		r = 2'h0;
		if (fn == `GCD_FN_LOOP1_CLK) begin
			r = {1'b1, lc[0]};
		end else if (fn == `GCD_FN_LOOP2_CLK) begin
			r = {1'b1, lc[1]};
		end else if (fn == `GCD_FN_LOOP3_CLK) begin
			r = {1'b1, lc[2]};
		end else if (fn == `GCD_FN_LOOP1_LOCK) begin
			r = {1'b1, lk[0]};
		end else if (fn == `GCD_FN_LOOP2_LOCK) begin
			r = {1'b1, lk[1]};
		end else if (fn == `GCD_FN_LOOP3_LOCK) begin
			r = {1'b1, lk[2]};
		end else if (fn == `GCD_FN_SYS_CLK) begin
			r = {1'b1, sc};
		end else if (fn == `GCD_FN_ASYNC_CLK) begin
			r = {1'b1, ac};
		end
		return r;
	endfunction

	// Bus channel handshakes; one write and one read in flight at most.
	logic aw_go;
	logic w_go;
	logic wr_go;
	logic ar_go;
	logic [9:0] ar_idx;
	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready = !w_full_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign aw_go = s_axi_awvalid && s_axi_awready;
	assign w_go = s_axi_wvalid && s_axi_wready;
	assign wr_go = aw_full_r && w_full_r;
	assign ar_go = s_axi_arvalid && s_axi_arready;
	assign ar_idx = s_axi_araddr[11:2];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b0;
			aw_idx_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bresp_r <= `GCD_RESP_OKAY;
		end else begin
			if (aw_go) begin
				aw_full_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[11:2];
			end else if (wr_go) begin
				aw_full_r <= 1'b0;
			end
			if (w_go) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= mapped(aw_idx_r) ? `GCD_RESP_OKAY
					: `GCD_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `GCD_RESP_OKAY;
		end else if (ar_go) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= mapped(ar_idx) ? `GCD_RESP_OKAY : `GCD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	always_comb begin
		rd_word = 32'h0;
		if (ar_idx == `GCD_SYS_IDX) begin
			rd_word = {16'h0, sys_ctrl_r};
		end else if (ar_idx == `GCD_ASYNC_IDX) begin
			rd_word = {16'h0, async_ctrl_r};
		end else if (ar_idx == `GCD_LOOP1_IDX) begin
			rd_word = {16'h0, loop_ctrl_r[0]};
		end else if (ar_idx == `GCD_LOOP2_IDX) begin
			rd_word = {16'h0, loop_ctrl_r[1]};
		end else if (ar_idx == `GCD_LOOP3_IDX) begin
			rd_word = {16'h0, loop_ctrl_r[2]};
		end else if (ar_idx == `GCD_STAT_IDX) begin
			rd_word = {29'h0, status_r};
		end else if (ar_idx == `GCD_MASK_IDX) begin
			rd_word = {29'h0, mask_r};
		end else if (ar_idx == `GCD_LEVEL_IDX) begin
			rd_word = {29'h0, freq_lock};
		end
		for (int p = 0; p < NPINS; p++) begin
			if (ar_idx == 10'(`GCD_PIN_IDX + p)) begin
				rd_word = {23'h0, pin_fn_r[p]};
			end
		end
	end

	// Register writes.
	logic wr_sys;
	logic wr_async;
	logic wr_stat;
	logic wr_mask;
	assign wr_sys = wr_go && (aw_idx_r == `GCD_SYS_IDX);
	assign wr_async = wr_go && (aw_idx_r == `GCD_ASYNC_IDX);
	assign wr_stat = wr_go && (aw_idx_r == `GCD_STAT_IDX);
	assign wr_mask = wr_go && (aw_idx_r == `GCD_MASK_IDX);
	assign clr = (wr_stat && wstrb_r[0]) ? wdata_r[NL-1:0] : '0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sys_ctrl_r <= `GCD_OUT_RST;
			async_ctrl_r <= `GCD_OUT_RST;
			mask_r <= '0;
			status_r <= '0;
		end else begin
			if (wr_sys) begin
				sys_ctrl_r <= merge(sys_ctrl_r, wdata_r, wstrb_r,
					`GCD_OUT_WMASK);
			end
			if (wr_async) begin
				async_ctrl_r <= merge(async_ctrl_r, wdata_r, wstrb_r,
					`GCD_OUT_WMASK);
			end
			if (wr_mask && wstrb_r[0]) begin
				mask_r <= wdata_r[NL-1:0];
			end
			// A new edge wins over a clear in the same cycle.
			status_r <= (status_r & ~clr) | evt;
		end
	end

	assign irq = |(status_r & mask_r);

	gcd_edge #(.N(NL)) u_edge (
		.clk(clk),
		.resetn(resetn),
		.level(freq_lock),
		.evt(evt)
	);

	// Loop dividers only read the VCO tick and never drive the loop.
	gcd_div_if #(.W(7)) loop_if [NL] ();
	for (genvar i = 0; i < NL; i++) begin : g_loop
		logic wr_loop;
		assign wr_loop = wr_go && (aw_idx_r == LOOP_IDX[i]);
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				loop_ctrl_r[i] <= `GCD_LOOP_RST;
			end else if (wr_loop) begin
				loop_ctrl_r[i] <= merge(loop_ctrl_r[i], wdata_r, wstrb_r,
					`GCD_LOOP_WMASK);
			end
		end
		assign loop_if[i].tick = vco_tick[i];
		assign loop_if[i].div =
			loop_ctrl_r[i][`GCD_LOOP_DIV_MSB:`GCD_LOOP_DIV_LSB];
		// Reserved codes below six keep the output off.
		assign loop_if[i].en = loop_ctrl_r[i][`GCD_LOOP_EN_BIT] &&
			(loop_if[i].div >= `GCD_LOOP_DIV_MIN);
		assign loop_clk[i] = loop_if[i].clk_out;
		gcd_div #(.W(7)) u_div (
			.clk(clk),
			.resetn(resetn),
			.d(loop_if[i])
		);
	end

	gcd_div_if #(.W(5)) out_if [2] ();
	assign out_if[0].tick = pick_tick(
		sys_ctrl_r[`GCD_OUT_SEL_MSB:`GCD_OUT_SEL_LSB],
		sys_rate_field, sys_src_tick, sys_src_tick_44k);
	assign out_if[0].div =
		sys_ctrl_r[`GCD_OUT_DIV_MSB:`GCD_OUT_DIV_LSB];
	assign out_if[0].en = sys_ctrl_r[`GCD_OUT_EN_BIT];
	assign out_if[1].tick = pick_tick(
		async_ctrl_r[`GCD_OUT_SEL_MSB:`GCD_OUT_SEL_LSB],
		async_rate_field, async_src_tick, async_src_tick_44k);
	assign out_if[1].div =
		async_ctrl_r[`GCD_OUT_DIV_MSB:`GCD_OUT_DIV_LSB];
	assign out_if[1].en = async_ctrl_r[`GCD_OUT_EN_BIT];
	assign sys_clk = out_if[0].clk_out;
	assign async_clk = out_if[1].clk_out;
	for (genvar k = 0; k < 2; k++) begin : g_out
		gcd_div #(.W(5)) u_div (
			.clk(clk),
			.resetn(resetn),
			.d(out_if[k])
		);
	end

	// Pin function selection; pins with other codes are left undriven.
	for (genvar p = 0; p < NPINS; p++) begin : g_pin
		logic [1:0] r;
		assign r = pin_route(pin_fn_r[p], loop_clk, freq_lock, sys_clk,
			async_clk);
		assign route_oe[p] = r[1];
		assign route_val[p] = r[0];
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				pin_fn_r[p] <= '0;
			end else if (wr_go && aw_idx_r == 10'(`GCD_PIN_IDX + p)) begin
				pin_fn_r[p] <= 9'(merge({7'h0, pin_fn_r[p]}, wdata_r,
					wstrb_r, `GCD_PIN_WMASK));
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gpio_out_r <= '0;
			gpio_oe_r <= '0;
		end else begin
			gpio_out_r <= route_val;
			gpio_oe_r <= route_oe;
		end
	end

	assign gpio_out = gpio_out_r;
	assign gpio_oe = gpio_oe_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_route_loop;
		(pin_fn_r[0] == `GCD_FN_LOOP1_CLK) |=>
			gpio_oe[0] && (gpio_out[0] == $past(loop_clk[0]));
	endproperty
	a_route_loop: assert property (p_route_loop)
		else $error("pin 0 does not carry loop 1 clock");

	property p_route_lock;
		(pin_fn_r[0] == `GCD_FN_LOOP2_LOCK) |=>
			gpio_oe[0] && (gpio_out[0] == $past(freq_lock[1]));
	endproperty
	a_route_lock: assert property (p_route_lock)
		else $error("pin 0 does not carry loop 2 lock flag");

	property p_route_sys;
		(pin_fn_r[0] == `GCD_FN_SYS_CLK) |=>
			gpio_oe[0] && (gpio_out[0] == $past(sys_clk));
	endproperty
	a_route_sys: assert property (p_route_sys)
		else $error("pin 0 does not carry system derived clock");

	property p_evt_cause;
		$changed(freq_lock) |-> (evt == (freq_lock ^ $past(freq_lock)));
	endproperty
	a_evt_cause: assert property (p_evt_cause)
		else $error("lock edge did not raise matching event");

	property p_edge_set;
		(evt != '0) |=> ((status_r & $past(evt)) == $past(evt));
	endproperty
	a_edge_set: assert property (p_edge_set)
		else $error("lock event did not set status");

	property p_sticky;
		1'b1 |=> ((($past(status_r) & ~$past(clr)) & ~status_r) == '0);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit dropped without a clear");

	property p_poll;
		(ar_go && ar_idx == `GCD_STAT_IDX) |=>
			s_axi_rvalid && (s_axi_rdata[2:0] == $past(status_r));
	endproperty
	a_poll: assert property (p_poll)
		else $error("status read does not return latched events");

	c_irq: cover property ($rose(irq));
	c_loop_clk: cover property ($rose(loop_clk[0]));
	c_sys_pin: cover property (gpio_oe[0] && $rose(gpio_out[0]));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// *** gcd_params.svh ***
// Register map, field positions, reset values and function codes.
`ifndef GCD_PARAMS_SVH
`define GCD_PARAMS_SVH
`define GCD_SYS_IDX 10'h149
`define GCD_ASYNC_IDX 10'h14a
`define GCD_LOOP1_IDX 10'h18a
`define GCD_LOOP2_IDX 10'h1aa
`define GCD_LOOP3_IDX 10'h1ca
`define GCD_STAT_IDX 10'h200
`define GCD_MASK_IDX 10'h201
`define GCD_LEVEL_IDX 10'h202
`define GCD_PIN_IDX 10'h210
`define GCD_LOOP_EN_BIT 0
`define GCD_LOOP_DIV_LSB 1
`define GCD_LOOP_DIV_MSB 7
`define GCD_OUT_EN_BIT 15
`define GCD_OUT_DIV_LSB 3
`define GCD_OUT_DIV_MSB 7
`define GCD_OUT_SEL_LSB 0
`define GCD_OUT_SEL_MSB 2
`define GCD_LOOP_RST 16'h000c
`define GCD_OUT_RST 16'h0000
`define GCD_LOOP_WMASK 16'h00ff
`define GCD_OUT_WMASK 16'h80ff
`define GCD_PIN_WMASK 16'h01ff
`define GCD_LOOP_DIV_MIN 7'h06
`define GCD_FN_LOOP1_CLK 9'h010
`define GCD_FN_LOOP2_CLK 9'h011
`define GCD_FN_LOOP3_CLK 9'h012
`define GCD_FN_LOOP1_LOCK 9'h018
`define GCD_FN_LOOP2_LOCK 9'h019
`define GCD_FN_LOOP3_LOCK 9'h01a
`define GCD_FN_SYS_CLK 9'h040
`define GCD_FN_ASYNC_CLK 9'h041
`define GCD_RATE_44K 2'h1
`define GCD_RESP_OKAY 2'h0
`define GCD_RESP_SLVERR 2'h2
`endif

// *** gcd_pkg.sv ***
// Shared types for the clock output block.
package gcd_pkg;
	typedef logic [15:0] gcd_reg_t;
	typedef logic [8:0] gcd_fn_t;
	typedef logic [1:0] gcd_resp_t;
	typedef logic [11:0] gcd_addr_t;
endpackage

// *** gcd_div_if.sv ***
// Connection between the register file and one clock divider.
`timescale 1ns/100ps
interface gcd_div_if #(
	parameter int W = 7
) ();
	logic tick;
	logic en;
	logic [W-1:0] div;
	logic clk_out;
	modport ctrl (output tick, output en, output div, input clk_out);
	modport sink (input tick, input en, input div, output clk_out);
endinterface

// *** gcd_div.sv ***
// Glitch-free programmable divider stepped by a source tick.
`timescale 1ns/100ps
module gcd_div #(
	parameter int W = 7
) (
	input wire logic clk,
	input wire logic resetn,
	gcd_div_if.sink d
);
	import gcd_pkg::*;
	logic [W-1:0] cnt_r;
	logic [W-1:0] div_r;
	logic [W-1:0] cnt_nxt;
	logic [W-1:0] div_nxt;
	logic en_r;
	logic out_r;
	logic wrap;
	logic en_nxt;
	logic out_nxt;

	// Settings are taken only where a period ends, so no runt can appear.
	assign wrap = !en_r || (cnt_r == W'(div_r - 1'b1));
	assign en_nxt = wrap ? (d.en && d.div >= W'(2)) : en_r;
	assign div_nxt = wrap ? d.div : div_r;
	assign cnt_nxt = wrap ? '0 : W'(cnt_r + 1'b1);
	// Odd ratios give a high phase one tick shorter than the low phase.
	assign out_nxt = en_nxt && (cnt_nxt < (div_nxt >> 1));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			div_r <= '0;
			en_r <= 1'b0;
			out_r <= 1'b0;
		end else if (d.tick) begin
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			en_r <= en_nxt;
			out_r <= out_nxt;
		end
	end

	assign d.clk_out = out_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_gate_off;
		!en_r |-> !out_r;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("divider output high while disabled");

	property p_hold_mid;
		!wrap |=> (div_r == $past(div_r)) && (en_r == $past(en_r));
	endproperty
	a_hold_mid: assert property (p_hold_mid)
		else $error("divider settings changed inside a period");

	property p_period_end;
		(en_r && cnt_r == W'(div_r - 1'b1)) |-> !out_r;
	endproperty
	a_period_end: assert property (p_period_end)
		else $error("divider output high in last tick of period");
endmodule

// *** gcd_edge.sv ***
// Both-edge event detector for the loop lock flags.
`timescale 1ns/100ps
module gcd_edge #(
	parameter int N = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [N-1:0] level,
	output logic [N-1:0] evt
);
	import gcd_pkg::*;
	logic [N-1:0] lvl_r;
	logic primed_r;

	// The first sample after reset only primes, so a flag already high
	// at release is not taken for an edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl_r <= '0;
			primed_r <= 1'b0;
		end else begin
			lvl_r <= level;
			primed_r <= 1'b1;
		end
	end

	assign evt = primed_r ? (level ^ lvl_r) : '0;
endmodule

// *** gcd_far_end.sv ***
// Far-end model: source tick generator and clock receiver on one pin.
`timescale 1ns/100ps
module gcd_far_end (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin,
	output logic [2:0] vco_tick,
	output logic [3:0] src_tick,
	output logic [3:0] src_tick_44k,
	output int period,
	output int high
);
	logic [3:0] tc_r;
	logic [1:0] t3_r;
	logic prev_r;
	int cnt_r;
	int run_r;
	// Ticks are spaced out so that a divider counting clocks, not ticks,
	// shows up as a wrong period.
	assign vco_tick = {3{tc_r[0]}};
	// Sources run from reset on and never outpace the clock.
	assign src_tick = {tc_r[0], tc_r[1:0] == 2'h0, tc_r[2:0] == 3'h0,
		tc_r == 4'h0};
	assign src_tick_44k = {4{t3_r == 2'h0}};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tc_r <= 4'h1;
			t3_r <= 2'h1;
			prev_r <= 1'b0;
			cnt_r <= 0;
			run_r <= 0;
			period <= 0;
			high <= 0;
		end else begin
			tc_r <= tc_r + 4'h1;
			t3_r <= (t3_r == 2'h2) ? 2'h0 : t3_r + 2'h1;
			prev_r <= pin;
			cnt_r <= (pin && !prev_r) ? 1 : cnt_r + 1;
			run_r <= pin ? run_r + 1 : 0;
			if (pin && !prev_r)
				period <= cnt_r;
			if (!pin && prev_r)
				high <= run_r;
		end
	end
endmodule

// *** gpio_clock_output_dividers_bench.sv ***
// Self-checking bench for the clock output block.
`timescale 1ns/100ps
`include "gcd_params.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	n_errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
	end end
module gpio_clock_output_dividers_bench;
	import gcd_pkg::*;
	typedef struct {
		logic [8:0] fn;
		logic [9:0] idx;
		logic [15:0] val;
		logic [4:0] rate;
		int sp;
	} gcd_row_s;
	logic clk = 1'b0;
	logic resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, is_loop, seen;
	gcd_addr_t awaddr, araddr;
	gcd_resp_t bresp, rresp, rs;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, src_tick, src_44k, gpio_out, gpio_oe;
	logic [2:0] vco_tick, freq_lock;
	logic [4:0] sys_rate, async_rate;
	logic [6:0] dv;
	int period, high, n_errors, n_checks, cycles;
	logic [9:0] ids [5] = '{`GCD_LOOP1_IDX, `GCD_LOOP2_IDX, `GCD_LOOP3_IDX,
		`GCD_SYS_IDX, `GCD_ASYNC_IDX};
	logic [15:0] rvals [5] = '{16'h000c, 16'h000c, 16'h000c, 16'h0, 16'h0};
	gcd_row_s rows [8] = '{
		'{9'h010, `GCD_LOOP1_IDX, 16'h000f, 5'h00, 2},
		'{9'h011, `GCD_LOOP2_IDX, 16'h000d, 5'h00, 2},
		'{9'h012, `GCD_LOOP3_IDX, 16'h00ff, 5'h00, 2},
		'{9'h040, `GCD_SYS_IDX, 16'h8022, 5'h00, 4},
		'{9'h040, `GCD_SYS_IDX, 16'h8010, 5'h00, 16},
		'{9'h040, `GCD_SYS_IDX, 16'h8023, 5'h08, 3},
		'{9'h041, `GCD_ASYNC_IDX, 16'h80f1, 5'h00, 8},
		'{9'h041, `GCD_ASYNC_IDX, 16'h8023, 5'h08, 3}};
	gcd_top u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .vco_tick(vco_tick), .freq_lock(freq_lock),
		.sys_src_tick(src_tick), .sys_src_tick_44k(src_44k),
		.sys_rate_field(sys_rate), .async_src_tick(src_tick),
		.async_src_tick_44k(src_44k), .async_rate_field(async_rate),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq));
	gcd_far_end u_far (.clk(clk), .resetn(resetn), .pin(gpio_out[0]),
		.vco_tick(vco_tick), .src_tick(src_tick), .src_tick_44k(src_44k),
		.period(period), .high(high));
	always #50 clk = ~clk;
	task automatic stop_test();
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic wr(input logic [9:0] idx, input logic [15:0] v,
		output gcd_resp_t r);
		logic a, w, done;
		@(posedge clk);
		a = 1'b0;
		w = 1'b0;
		done = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (!a && awready) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] v,
		output gcd_resp_t r);
		logic a, done;
		@(posedge clk);
		a = 1'b0;
		done = 1'b0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (!a && arready) begin
				a = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
		{awaddr, araddr, wdata} <= 56'h0;
		wstrb <= 4'hf;
		freq_lock <= 3'h0;
		sys_rate <= 5'h00;
		async_rate <= 5'h00;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			is_loop = rows[i].val[15] == 1'b0;
			dv = is_loop ? rows[i].val[7:1] : {2'b00, rows[i].val[7:3]};
			sys_rate <= rows[i].rate;
			async_rate <= rows[i].rate;
			// Clock is stopped while its divider changes.
			wr(rows[i].idx, rows[i].val & (is_loop ? 16'hfffe : 16'h7fff), rs);
			// The old period must run out before the new setting goes in.
			repeat (300) @(posedge clk);
			wr(rows[i].idx, rows[i].val, rs);
			wr(`GCD_PIN_IDX, {7'h00, rows[i].fn}, rs);
			repeat (4 * int'(dv) * rows[i].sp + 40) @(posedge clk);
			rd(rows[i].idx, d, rs);
			`CHK("ctrl readback", rows[i].val, d[15:0])
			`CHK("pin enable", 4'b0001, gpio_oe)
			`CHK("period", int'(dv) * rows[i].sp, period)
			`CHK("high time", int'(dv) / 2 * rows[i].sp, high)
		end
		wr(`GCD_LOOP1_IDX, 16'h000e, rs);
		wr(`GCD_PIN_IDX, 16'h0010, rs);
		repeat (300) @(posedge clk);
		seen = 1'b0;
		repeat (60) begin
			@(posedge clk);
			seen = seen | gpio_out[0];
		end
		`CHK("disabled clock", 1'b0, seen)
		wr(`GCD_SYS_IDX, 16'hffff, rs);
		rd(`GCD_SYS_IDX, d, rs);
		`CHK("sys fields", 32'h000080ff, d)
		wr(10'h100, 16'h1234, rs);
		`CHK("unmapped write", `GCD_RESP_SLVERR, rs)
		rd(10'h100, d, rs);
		`CHK("unmapped read", `GCD_RESP_SLVERR, rs)
		wr(`GCD_PIN_IDX, 16'h0018, rs);
		freq_lock <= 3'b001;
		repeat (4) @(posedge clk);
		`CHK("lock on pin", 1'b1, gpio_out[0])
		rd(`GCD_STAT_IDX, d, rs);
		`CHK("rise event", 32'h1, d)
		`CHK("masked irq", 1'b0, irq)
		wr(`GCD_MASK_IDX, 16'h0007, rs);
		`CHK("irq on", 1'b1, irq)
		rd(`GCD_LEVEL_IDX, d, rs);
		`CHK("lock level", 32'h1, d)
		wr(`GCD_STAT_IDX, 16'h0001, rs);
		rd(`GCD_STAT_IDX, d, rs);
		`CHK("cleared", 32'h0, d)
		`CHK("irq off", 1'b0, irq)
		freq_lock <= 3'b101;
		repeat (2) @(posedge clk);
		freq_lock <= 3'b100;
		wr(`GCD_PIN_IDX, 16'h001a, rs);
		rd(`GCD_STAT_IDX, d, rs);
		`CHK("both edges", 32'h5, d)
		`CHK("third lock pin", 1'b1, gpio_out[0])
		`CHK("irq again", 1'b1, irq)
		freq_lock <= 3'b010;
		wr(`GCD_PIN_IDX, 16'h0019, rs);
		repeat (2) @(posedge clk);
		`CHK("second lock pin", 1'b1, gpio_out[0])
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		foreach (ids[k]) begin
			rd(ids[k], d, rs);
			`CHK("reset value", {16'h0000, rvals[k]}, d)
		end
		rd(`GCD_STAT_IDX, d, rs);
		`CHK("no event at release", 32'h0, d)
		`CHK("pins idle", 4'b0000, gpio_oe)
		stop_test();
	end
endmodule
